// [bench/smu_peer.sv]
`timescale 1ns/10ps
// ==========================================================
// far-side serial device, acting as a slave of this port
module smu_peer (
  input  wire logic        clk,
  input  wire logic        i_txd,
  input  wire logic        i_sck,
  input  wire logic [15:0] i_bit_clks,
  output logic             o_rxd
);
  // idle line sits high between frames
  initial o_rxd = 1'b1;

  // low start first, data lsb first, each level held a whole bit
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      o_rxd = bits[i];
      repeat (i_bit_clks) @(negedge clk);
    end
    o_rxd = 1'b1;
    @(negedge clk);
  endtask

  // samples mid-bit from the falling start edge
  task automatic capture(input int n, output logic [15:0] bits);
    bits = '0;
    while (i_txd !== 1'b0) @(negedge clk);
    repeat (i_bit_clks / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = i_txd;
      if (i < n - 1) repeat (i_bit_clks) @(negedge clk);
    end
  endtask

  // shift clock rises mid-bit, when the data has settled
  task automatic cap_sync(output logic [7:0] bits);
    for (int i = 0; i < 8; i++) begin
      @(posedge i_sck);
      bits[i] = i_txd;
    end
  endtask

  task automatic send_sync(input logic [7:0] bits);
    for (int i = 0; i < 8; i++) begin
      @(negedge i_sck);
      o_rxd = bits[i];
    end
    repeat (24) @(negedge clk);
    // released line must not keep showing the last bit
    o_rxd = ~bits[7];
  endtask
endmodule

// [bench/tb_top.sv]
`timescale 1ns/10ps
module tb_top
  import smu_pkg::*;
;
  typedef struct packed {
    logic [1:0] md;
    logic [1:0] src;
    logic [2:0] sel;
    logic [5:0] f;  // len7, parity, odd, two stops, select bit, service
    logic [7:0] d;
  } smu_row_t;

  // ==========================================================
  // ordinary frames
  smu_row_t rows [6] = '{
    '{2'h0, 2'h0, 3'h7, 6'h00, 8'ha5},  // generator rate
    '{2'h0, 2'h2, 3'h0, 6'h31, 8'h3c},  // 7 bits, even, timer
    '{2'h0, 2'h1, 3'h0, 6'h1c, 8'h81},  // odd, two stops, ext pin
    '{2'h1, 2'h2, 3'h0, 6'h32, 8'h5a},  // select set, no parity
    '{2'h1, 2'h2, 3'h0, 6'h01, 8'h00},  // select clear
    '{2'h0, 2'h0, 3'h6, 6'h10, 8'h6e}   // even, second rate
  };

  logic clk = 1'b0, rst = 1'b1, tick = 1'b0;
  logic [1:0] md = 2'h0, src = 2'h2;
  logic [2:0] sel = 3'h0;
  logic len7 = 1'b0, par_en = 1'b0, par_odd = 1'b0, stop2 = 1'b0, addr_sel = 1'b0;
  logic tx_wr = 1'b0, tx_ack = 1'b0, err_clr = 1'b0, rx_ready = 1'b0;
  logic rx_ioe = 1'b0, tx_ioe = 1'b0, tx_en = 1'b1;
  logic [7:0] tx_data = 8'h00, g8;
  logic [15:0] fb, got, g2;
  wire logic rxd, txd, sck, buf_empty, rx_valid, fe, pe, ore, rx_irq, tx_irq, rx_io, tx_io;
  wire logic [7:0] rx_data;
  int failures = 0, samples_checked = 0, bclk = 32, fn, k, n0;
  smu_row_t r;

  initial forever #12.5 clk = ~clk;
  always @(negedge clk) tick <= ~tick;

  smu_top DUT (
    .I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_MODE(md), .I_LEN7(len7),
    .I_PAR_EN(par_en), .I_PAR_ODD(par_odd), .I_STOP2(stop2), .I_ADDR_SEL(addr_sel),
    .I_CLK_SRC(src), .I_BAUD_SEL(sel), .I_TX_EN(tx_en), .I_RX_EN(1'b1),
    .I_EXT_CLK(tick), .I_TMR0(tick), .I_RXD(rxd), .O_TXD(txd), .O_SCK(sck),
    .I_TX_WR(tx_wr), .I_TX_DATA(tx_data), .O_TX_BUF_EMPTY(buf_empty),
    .O_RX_VALID(rx_valid), .O_RX_DATA(rx_data), .I_RX_READY(rx_ready),
    .I_ERR_CLR(err_clr), .O_FE(fe), .O_PE(pe), .O_ORE(ore),
    .I_RX_IE(1'b1), .I_TX_IE(1'b1), .I_RX_IOT_EN(rx_ioe), .I_TX_IOT_EN(tx_ioe),
    .I_TX_ACK(tx_ack), .O_RX_IRQ(rx_irq), .O_TX_IRQ(tx_irq), .O_RX_IOT(rx_io), .O_TX_IOT(tx_io)
  );

  smu_peer peer (.clk(clk), .i_txd(txd), .i_sck(sck), .i_bit_clks(bclk[15:0]), .o_rxd(rxd));

  // ==========================================================
  // helpers
  function automatic void mk(input smu_row_t x, output logic [15:0] b, output int n);
    int nd;
    nd = (x.md == 2'h0 && x.f[5]) ? 7 : 8;
    b = 16'hffff;
    b[0] = 1'b0;
    for (int i = 0; i < nd; i++) b[1+i] = x.d[i];
    n = nd + 1;
    if (x.md == 2'h1) begin
      b[n] = x.f[1];
      n++;
    end else if (x.f[4]) begin
      b[n] = ^(x.d & (nd == 7 ? 8'h7f : 8'hff)) ^ x.f[3];
      n++;
    end
    n += (x.md == 2'h0 && x.f[2]) ? 2 : 1;
  endfunction

  task automatic chk_v(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] d);
    tx_data = d;
    tx_wr = 1'b1;
    @(negedge clk);
    tx_wr = 1'b0;
  endtask

  task automatic ack();
    {tx_ack, err_clr, rx_ready} = 3'h7;
    repeat (4) @(negedge clk);
    {tx_ack, err_clr, rx_ready} = 3'h0;
    repeat (2) @(negedge clk);
  endtask

  task automatic print_verdict();
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // sequence
  initial begin
    repeat (19) @(negedge clk);
    chk_v({txd, sck, buf_empty, rx_valid, fe, pe, ore, rx_irq, tx_irq, rx_io, tx_io},
          16'h0700);
    @(negedge clk);
    rst = 1'b0;
    foreach (rows[i]) begin
      r = rows[i];
      mk(r, fb, fn);
      {md, src, sel, len7, par_en, par_odd, stop2, addr_sel} = {r.md, r.src, r.sel, r.f[5:1]};
      {rx_ioe, tx_ioe} = {2{r.f[0]}};
      bclk = (r.src == 2'h0) ? SMU_OVS * (SMU_CLK_HZ / (SMU_OVS * SMU_RATE[r.sel])) : 32;
      @(negedge clk);
      fork
        wr(r.d);
        peer.capture(fn, got);
        peer.send(fb, fn);
      join
      for (k = 0; k < 2 * bclk && !(rx_valid === 1'b1 && (tx_irq | tx_io) === 1'b1); k++)
        @(negedge clk);
      @(negedge clk);
      chk_v(got, fb & ((16'h1 << fn) - 16'h1));
      chk_v(rx_data, r.d & ((r.md == 2'h0 && r.f[5]) ? 8'h7f : 8'hff));
      chk_v({fe, pe, ore}, 3'h0);
      chk_v({rx_irq, rx_io, tx_irq, tx_io}, {~r.f[0], r.f[0], ~r.f[0], r.f[0]});
      ack();
      chk_v({rx_irq, rx_io, tx_irq, tx_io}, 4'h0);
    end
    // second word queued behind a busy shifter, third write refused
    {md, src, len7, par_en, stop2, addr_sel, rx_ioe, tx_ioe} = {2'h0, 2'h2, 6'h00};
    bclk = 32;
    fork
      begin
        wr(8'h11);
        for (k = 0; k < 50 && buf_empty !== 1'b1; k++) @(negedge clk);
        wr(8'h22);
        @(negedge clk);
        chk_v(buf_empty, 1'b0);
        wr(8'h33);
      end
      begin
        peer.capture(10, got);
        peer.capture(10, g2);
      end
    join
    mk('{2'h0, 2'h2, 3'h0, 6'h00, 8'h11}, fb, fn);
    chk_v(got, fb & 16'h03ff);
    mk('{2'h0, 2'h2, 3'h0, 6'h00, 8'h22}, fb, fn);
    chk_v(g2, fb & 16'h03ff);
    n0 = 0;
    repeat (400) begin
      @(negedge clk);
      n0 += int'(txd === 1'b0);
    end
    chk_v(16'(n0), 16'h0000);
    ack();
    // framing error, then parity error
    for (int j = 0; j < 2; j++) begin
      par_en = j[0];
      mk('{2'h0, 2'h2, 3'h0, {1'b0, j[0], 4'h0}, 8'h77}, fb, fn);
      fb[9] = ~fb[9];
      peer.send(fb, fn);
      for (k = 0; k < 200 && (fe | pe) !== 1'b1; k++) @(negedge clk);
      @(negedge clk);
      chk_v({fe, pe, rx_irq}, {~j[0], j[0], 1'b1});
      repeat (400) @(negedge clk);
      ack();
      chk_v({fe, pe}, 2'h0);
    end
    // fill the receive path past its depth, then drain it
    par_en = 1'b0;
    ack();
    for (int j = 0; j < 34; j++) begin
      mk('{2'h0, 2'h2, 3'h0, 6'h00, 8'(j)}, fb, fn);
      peer.send(fb, fn);
    end
    repeat (40) @(negedge clk);
    chk_v({ore, rx_valid, rx_data}, 10'h300);
    rx_ready = 1'b1;
    n0 = 0;
    repeat (60) begin
      n0 += int'(rx_valid === 1'b1);
      @(negedge clk);
    end
    rx_ready = 1'b0;
    chk_v(16'(n0), 16'(SMU_FIFO_DEPTH + 1));
    ack();
    // clock-synchronous word both ways
    md = 2'h2;
    fork
      wr(8'hc5);
      peer.cap_sync(g8);
      peer.send_sync(8'h96);
    join
    for (k = 0; k < 100 && rx_valid !== 1'b1; k++) @(negedge clk);
    chk_v({g8, rx_data}, 16'hc596);
    print_verdict();
  end

  initial begin
    repeat (95000) @(posedge clk);
    failures++;
    $display("[ERR] %0t run did not finish", $time);
    print_verdict();
  end
endmodule

// [design/smu_baud.sv]
`timescale 1ns/10ps
module smu_baud
  import smu_pkg::*;
(
  // clock, reset, enable
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  // source selection
  input  wire logic [1:0] i_src,
  input  wire logic [2:0] i_sel,
  // external sources, already in this clock domain
  input  wire logic       i_ext,
  input  wire logic       i_tmr,
  // one pulse per oversampling step
  output logic            o_tick
);
  // ==========================================================
  logic [SMU_DIV_W-1:0] cnt_r;
  logic                 ext_d_r;
  logic                 tmr_d_r;

  wire [SMU_DIV_W-1:0] div    = smu_div(i_sel);
  wire                 gen_tc = (cnt_r >= div - SMU_DIV_W'(1));
  wire                 ext_up = i_ext && !ext_d_r;
  wire                 tmr_up = i_tmr && !tmr_d_r;
  wire                 tick_nxt = (i_src == SMU_SRC_GEN) ? gen_tc :
                                  (i_src == SMU_SRC_EXT) ? ext_up :
                                  (i_src == SMU_SRC_TMR) ? tmr_up : 1'b0;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r   <= '0;
      ext_d_r <= 1'b0;
      tmr_d_r <= 1'b0;
      o_tick  <= 1'b0;
    end else if (i_ce) begin
      cnt_r   <= gen_tc ? '0 : cnt_r + SMU_DIV_W'(1);
      ext_d_r <= i_ext;
      tmr_d_r <= i_tmr;
      o_tick  <= tick_nxt;
    end
  end
endmodule

// [design/smu_fifo.sv]
`timescale 1ns/10ps
module smu_fifo
  import smu_pkg::*;
#(
  parameter int W = SMU_DATA_W,
  parameter int D = SMU_FIFO_DEPTH
)(
  // clock, reset, enable
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // filling side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // draining side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  // ==========================================================
  // storage; depth must be a power of two so pointers wrap
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;

  wire push = i_in_valid && o_in_ready;
  wire load = (cnt_r != '0) && (!o_out_valid || i_out_ready);
  assign o_in_ready = (cnt_r != (AW+1)'(D));

  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem[wr_r] <= i_in_data;
    end
  end

  // ==========================================================
  // pointers and registered read port
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_r        <= '0;
      rd_r        <= '0;
      cnt_r       <= '0;
      o_out_valid <= 1'b0;
      o_out_data  <= '0;
    end else if (i_ce) begin
      if (push) wr_r <= wr_r + AW'(1);
      if (load) rd_r <= rd_r + AW'(1);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
      if (load) begin
        o_out_data  <= mem[rd_r];
        o_out_valid <= 1'b1;
      end else if (i_out_ready) begin
        o_out_valid <= 1'b0;
      end
    end
  end
endmodule

// [design/smu_top.sv]
`timescale 1ns/10ps
module smu_top
  import smu_pkg::*;
(
  // clock, reset, enable
  input  wire logic       I_CLK,
  input  wire logic       I_RST,
  input  wire logic       I_CE,
  // configuration
  input  wire logic [1:0] I_MODE,
  input  wire logic       I_LEN7,
  input  wire logic       I_PAR_EN,
  input  wire logic       I_PAR_ODD,
  input  wire logic       I_STOP2,
  input  wire logic       I_ADDR_SEL,
  input  wire logic [1:0] I_CLK_SRC,
  input  wire logic [2:0] I_BAUD_SEL,
  input  wire logic       I_TX_EN,
  input  wire logic       I_RX_EN,
  // rate sources
  input  wire logic       I_EXT_CLK,
  input  wire logic       I_TMR0,
  // serial pins
  input  wire logic       I_RXD,
  output logic            O_TXD,
  output logic            O_SCK,
  // transmit buffer
  input  wire logic       I_TX_WR,
  input  wire logic [7:0] I_TX_DATA,
  output logic            O_TX_BUF_EMPTY,
  // receive buffer
  output logic            O_RX_VALID,
  output logic [7:0]      O_RX_DATA,
  input  wire logic       I_RX_READY,
  // error flags
  input  wire logic       I_ERR_CLR,
  output logic            O_FE,
  output logic            O_PE,
  output logic            O_ORE,
  // requests
  input  wire logic       I_RX_IE,
  input  wire logic       I_TX_IE,
  input  wire logic       I_RX_IOT_EN,
  input  wire logic       I_TX_IOT_EN,
  input  wire logic       I_TX_ACK,
  output logic            O_RX_IRQ,
  output logic            O_TX_IRQ,
  output logic            O_RX_IOT,
  output logic            O_TX_IOT
);
  // ==========================================================
  // pin synchronisers
  logic rxd_s1_r;
  logic rxd_s2_r;
  logic ext_s1_r;
  logic ext_s2_r;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
    end else if (I_CE) begin
      rxd_s1_r <= I_RXD;
      rxd_s2_r <= rxd_s1_r;
      ext_s1_r <= I_EXT_CLK;
      ext_s2_r <= ext_s1_r;
    end
  end

  // ==========================================================
  // mode decode
  wire       md_async = (I_MODE == SMU_MD_ASYNC);
  wire       md_mp    = (I_MODE == SMU_MD_MP);
  wire       md_sync  = (I_MODE == SMU_MD_SYNC);
  wire       len7     = md_async && I_LEN7;
  wire [2:0] last_idx = len7 ? SMU_LAST7 : SMU_LAST8;
  wire [7:0] dmask    = len7 ? SMU_MASK7 : SMU_MASK8;
  wire       par_on   = (md_async && I_PAR_EN) || md_mp;
  wire       stop2    = md_async && I_STOP2;
  wire       tick;

  smu_baud u_baud (
    .i_clk  (I_CLK),
    .i_rst  (I_RST),
    .i_ce   (I_CE),
    .i_src  (I_CLK_SRC),
    .i_sel  (I_BAUD_SEL),
    .i_ext  (ext_s2_r),
    .i_tmr  (I_TMR0),
    .o_tick (tick)
  );

  // ==========================================================
  // transmitter: holding buffer plus shifter
  smu_st_t    tx_st_r;
  smu_st_t    tx_st_nxt;
  logic [7:0] tx_buf_r;
  logic [7:0] tx_sh_r;
  logic [2:0] tx_idx_r;
  logic [3:0] tx_tc_r;
  logic       tx_ad_r;
  logic       tx_fin_r;
  logic       txd_nxt;

  wire tx_load    = (tx_st_r == ST_IDLE) && !O_TX_BUF_EMPTY && I_TX_EN;
  wire tx_bit_end = tick && (tx_tc_r == SMU_TC_END) && (tx_st_r != ST_IDLE);
  wire tx_smp     = tick && (tx_tc_r == SMU_TC_MID) && (tx_st_r == ST_DATA);
  wire tx_last    = (tx_idx_r == last_idx);
  wire tx_done    = tx_bit_end &&
                    (((tx_st_r == ST_STOP) && !(stop2 && tx_idx_r == SMU_IDX0)) ||
                     (md_sync && (tx_st_r == ST_DATA) && tx_last));
  wire tx_pbit    = md_mp ? tx_ad_r : (^(tx_sh_r & dmask)) ^ I_PAR_ODD;
  wire sck_nxt    = !(md_sync && (tx_st_r == ST_DATA) && (tx_tc_r <= SMU_TC_MID));

  always_comb begin
    case (tx_st_r)
      ST_IDLE:  tx_st_nxt = tx_load ? (md_sync ? ST_DATA : ST_START) : ST_IDLE;
      ST_START: tx_st_nxt = tx_bit_end ? ST_DATA : ST_START;
      ST_DATA:  tx_st_nxt = !(tx_bit_end && tx_last) ? ST_DATA :
                            md_sync ? ST_IDLE : par_on ? ST_PAR : ST_STOP;
      ST_PAR:   tx_st_nxt = tx_bit_end ? ST_STOP : ST_PAR;
      ST_STOP:  tx_st_nxt = tx_done ? ST_IDLE : ST_STOP;
      default:  tx_st_nxt = ST_IDLE;
    endcase
  end

  // level stays put until the next bit boundary
  always_comb begin
    case (tx_st_r)
      ST_START: txd_nxt = 1'b0;
      ST_DATA:  txd_nxt = tx_sh_r[tx_idx_r];
      ST_PAR:   txd_nxt = tx_pbit;
      default:  txd_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      tx_st_r        <= ST_IDLE;
      tx_buf_r       <= 8'h00;
      tx_sh_r        <= 8'h00;
      tx_idx_r       <= SMU_IDX0;
      tx_tc_r        <= 4'h0;
      tx_ad_r        <= 1'b0;
      O_TX_BUF_EMPTY <= 1'b1;
      O_TXD          <= 1'b1;
      O_SCK          <= 1'b1;
    end else if (I_CE) begin
      tx_st_r <= tx_st_nxt;
      O_TXD   <= txd_nxt;
      O_SCK   <= sck_nxt;
      if (tx_load || (tx_bit_end && tx_st_nxt != tx_st_r)) tx_idx_r <= SMU_IDX0;
      else if (tx_bit_end) tx_idx_r <= tx_idx_r + 3'h1;
      if (tx_load) tx_tc_r <= 4'h0;
      else if (tick && tx_st_r != ST_IDLE) tx_tc_r <= tx_tc_r + 4'h1;
      if (tx_load) begin
        tx_sh_r        <= tx_buf_r;
        tx_ad_r        <= I_ADDR_SEL;
        O_TX_BUF_EMPTY <= 1'b1;
      end else if (I_TX_WR && O_TX_BUF_EMPTY) begin
        tx_buf_r       <= I_TX_DATA;
        O_TX_BUF_EMPTY <= 1'b0;
      end
    end
  end

  // ==========================================================
  // receiver; no slave address filter since this port is only master
  smu_st_t    rx_st_r;
  logic [3:0] rx_tc_r;
  logic [2:0] rx_idx_r;
  logic [7:0] rx_sh_r;
  logic       rx_pb_r;
  logic       rx_done_r;
  logic [7:0] rx_word_r;
  logic       fifo_ready;

  wire       rxd      = rxd_s2_r;
  wire       rx_end   = tick && (rx_tc_r == SMU_TC_END);
  wire [7:0] rx_word  = len7 ? {1'b0, rx_sh_r[7:1]} : rx_sh_r;
  wire       rx_fin_a = (rx_st_r == ST_STOP) && rx_end;
  wire       rx_fin_s = md_sync && I_RX_EN && tx_smp && (rx_idx_r == SMU_LAST8);
  wire       fe_ev    = rx_fin_a && !rxd;
  wire       pe_ev    = rx_fin_a && md_async && I_PAR_EN &&
                        ((^{rx_word, rx_pb_r}) != I_PAR_ODD);
  wire       ovr_ev   = rx_done_r && !fifo_ready;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_st_r  <= ST_IDLE;
      rx_tc_r  <= 4'h0;
      rx_idx_r <= SMU_IDX0;
      rx_sh_r  <= 8'h00;
      rx_pb_r  <= 1'b0;
    end else if (I_CE) begin
      case (rx_st_r)
        ST_IDLE: begin
          if (md_sync && tx_load) begin
            rx_idx_r <= SMU_IDX0;
          end else if (md_sync && I_RX_EN && tx_smp) begin
            rx_sh_r  <= {rxd, rx_sh_r[7:1]};
            rx_idx_r <= rx_idx_r + 3'h1;
          end else if (!md_sync && I_RX_EN && !rxd) begin
            rx_st_r <= ST_START;
            rx_tc_r <= 4'h0;
          end
        end
        ST_START: begin
          if (tick && rx_tc_r == SMU_TC_MID) begin
            // a start shorter than half a bit is glitch, not frame
            rx_st_r  <= rxd ? ST_IDLE : ST_DATA;
            rx_tc_r  <= 4'h0;
            rx_idx_r <= SMU_IDX0;
          end else if (tick) begin
            rx_tc_r <= rx_tc_r + 4'h1;
          end
        end
        ST_DATA: begin
          if (tick) rx_tc_r <= rx_tc_r + 4'h1;
          if (rx_end) begin
            rx_sh_r  <= {rxd, rx_sh_r[7:1]};
            rx_idx_r <= rx_idx_r + 3'h1;
            if (rx_idx_r == last_idx) rx_st_r <= par_on ? ST_PAR : ST_STOP;
          end
        end
        ST_PAR: begin
          if (tick) rx_tc_r <= rx_tc_r + 4'h1;
          if (rx_end) begin
            rx_pb_r <= rxd;
            rx_st_r <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tick) rx_tc_r <= rx_tc_r + 4'h1;
          if (rx_end) rx_st_r <= ST_IDLE;
        end
        default: rx_st_r <= ST_IDLE;
      endcase
    end
  end

  wire rx_req = O_RX_VALID || O_FE || O_PE || O_ORE;

  // ==========================================================
  // completion, flags and requests; a set wins over its clear
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_done_r <= 1'b0;
      rx_word_r <= 8'h00;
      tx_fin_r  <= 1'b0;
      O_FE      <= 1'b0;
      O_PE      <= 1'b0;
      O_ORE     <= 1'b0;
      O_RX_IRQ  <= 1'b0;
      O_TX_IRQ  <= 1'b0;
      O_RX_IOT  <= 1'b0;
      O_TX_IOT  <= 1'b0;
    end else if (I_CE) begin
      rx_done_r <= rx_fin_a || rx_fin_s;
      rx_word_r <= rx_fin_s ? {rxd, rx_sh_r[7:1]} : rx_word;
      tx_fin_r  <= tx_done || (tx_fin_r && !I_TX_ACK);
      O_FE      <= fe_ev  || (O_FE  && !I_ERR_CLR);
      O_PE      <= pe_ev  || (O_PE  && !I_ERR_CLR);
      O_ORE     <= ovr_ev || (O_ORE && !I_ERR_CLR);
      O_RX_IRQ  <= I_RX_IE && !I_RX_IOT_EN && rx_req;
      O_RX_IOT  <= I_RX_IE && I_RX_IOT_EN && rx_req;
      O_TX_IRQ  <= I_TX_IE && !I_TX_IOT_EN && tx_fin_r;
      O_TX_IOT  <= I_TX_IE && I_TX_IOT_EN && tx_fin_r;
    end
  end

  // a serial line cannot be stalled, so a full buffer drops the word
  smu_fifo #(
    .W (SMU_DATA_W),
    .D (SMU_FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk       (I_CLK),
    .i_rst       (I_RST),
    .i_ce        (I_CE),
    .i_in_valid  (rx_done_r),
    .i_in_data   (rx_word_r),
    .o_in_ready  (fifo_ready),
    .o_out_valid (O_RX_VALID),
    .o_out_data  (O_RX_DATA),
    .i_out_ready (I_RX_READY)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  sequence s_tx_fin;
    tx_done && I_CE && I_TX_IE && !I_TX_ACK ##1 I_CE && I_TX_IE && !I_TX_ACK;
  endsequence
  sequence s_stop1;
    tx_st_r == ST_STOP && tx_idx_r == SMU_IDX0 && tx_bit_end && I_CE;
  endsequence

  a_dbl_buf: assert property (tx_load && I_CE |=> O_TX_BUF_EMPTY)
    else $error("holding buffer not freed on load");
  a_sync_frame: assert property (md_sync |-> tx_st_r inside {ST_IDLE, ST_DATA})
    else $error("framing bits in synchronous mode");
  a_len7_end: assert property (tx_st_r == ST_DATA && tx_bit_end && I_CE && len7 &&
      tx_idx_r == SMU_LAST7 |=> tx_st_r != ST_DATA)
    else $error("seven bit word overran");
  a_nrz_hold: assert property ((tx_st_r == ST_DATA && !tx_bit_end && I_CE) ##1
      (tx_st_r == ST_DATA && I_CE) |=> $stable(O_TXD))
    else $error("line changed inside a bit");
  a_ovr_flag: assert property (ovr_ev && I_CE |=> O_ORE)
    else $error("overrun not flagged");
  a_mp_no_pe: assert property (md_mp |-> !pe_ev)
    else $error("parity checked in multiprocessor mode");
  a_rx_err_req: assert property ((O_FE || O_PE || O_ORE) && I_RX_IE && !I_RX_IOT_EN &&
      I_CE |=> O_RX_IRQ)
    else $error("error gave no receive request");
  a_tx_req: assert property (s_tx_fin |=> (O_TX_IRQ || O_TX_IOT))
    else $error("transmit completion gave no request");
  a_iot_route: assert property (I_TX_IOT_EN && I_CE |=> !O_TX_IRQ)
    else $error("transfer service and interrupt both chosen");
  a_two_stop: assert property (s_stop1 |=>
      (stop2 ? tx_st_r == ST_STOP : tx_st_r == ST_IDLE))
    else $error("wrong stop bit count");
  a_mp_adbit: assert property (tx_st_r == ST_PAR && md_mp && I_CE |=> O_TXD == tx_ad_r)
    else $error("select bit not sent");
  a_start_low: assert property (tx_st_r == ST_START && I_CE |=> !O_TXD)
    else $error("start bit not low");
  a_stop_high: assert property (tx_st_r == ST_STOP && I_CE |=> O_TXD)
    else $error("stop bit not high");
endmodule

// [inc/smu_pkg.sv]
package smu_pkg;
  // ==========================================================
  // clocking and bit timing
  localparam int unsigned SMU_CLK_HZ = 40_000_000;
  localparam int unsigned SMU_OVS    = 16;
  // eight selectable generator rates, in bit/s
  localparam int unsigned SMU_RATE [8] = '{1200, 2400, 4800, 9600,
                                           19200, 38400, 57600, 115200};
  localparam int unsigned SMU_DIV_W  = 16;
  localparam logic [3:0]  SMU_TC_MID = 4'h7;
  localparam logic [3:0]  SMU_TC_END = 4'hf;

  // ==========================================================
  // word layout
  localparam int unsigned SMU_DATA_W     = 8;
  localparam int unsigned SMU_FIFO_DEPTH = 32;
  localparam logic [2:0]  SMU_IDX0       = 3'h0;
  localparam logic [2:0]  SMU_LAST7      = 3'h6;
  localparam logic [2:0]  SMU_LAST8      = 3'h7;
  localparam logic [7:0]  SMU_MASK7      = 8'h7f;
  localparam logic [7:0]  SMU_MASK8      = 8'hff;

  // ==========================================================
  // modes, clock sources, frame states
  typedef enum logic [1:0] {
    SMU_MD_ASYNC = 2'b00,
    SMU_MD_MP    = 2'b01,
    SMU_MD_SYNC  = 2'b10
  } smu_mode_t;

  typedef enum logic [1:0] {
    SMU_SRC_GEN = 2'b00,
    SMU_SRC_EXT = 2'b01,
    SMU_SRC_TMR = 2'b10
  } smu_src_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_PAR   = 3'b011,
    ST_STOP  = 3'b100
  } smu_st_t;

  // rounds down: the generator never runs slower than asked
  function automatic logic [SMU_DIV_W-1:0] smu_div(input logic [2:0] sel);
    smu_div = SMU_DIV_W'(SMU_CLK_HZ / (SMU_OVS * SMU_RATE[sel]));
  endfunction
endpackage
